// ---- hrdoc_rx_sched.sv ----
`timescale 1ns/1ps
`default_nettype none
module hrdoc_rx_sched #(
  parameter int unsigned ENTRIES   = hrdoc_pkg::TBL_ENTRIES,
  parameter int unsigned IW        = hrdoc_pkg::TBL_IDX_W,
  parameter int unsigned CHAIN_CYC = hrdoc_pkg::CHAIN_CYC,
  parameter int unsigned BUF_LEN   = 64
) (
  input  wire logic                                        i_core_clk,
  input  wire logic                                        i_rst_b,
  input  wire logic                                        i_rx_valid,
  input  wire hrdoc_pkg::hrdoc_rx_beat_type                i_rx_beat,
  input  wire logic [15:0]                                 i_rx_addr,
  input  wire logic [7:0]                                  i_address_match,
  input  wire logic [IW:0]                                 i_address_table_setting,
  input  wire hrdoc_pkg::hrdoc_tbl_entry_type [ENTRIES-1:0] i_addr_table,
  input  wire logic                                        i_chain_en,
  input  wire logic                                        i_report_busy,
  input  wire logic                                        i_eof_done,
  input  wire logic                                        i_tx_valid,
  input  wire logic [7:0]                                  i_tx_data,
  output logic                                             o_tx_valid,
  output logic      [7:0]                                  o_tx_data,
  output logic                                             o_dma_start,
  output logic                                             o_dma_valid,
  input  wire logic                                        i_dma_ready,
  output hrdoc_pkg::hrdoc_rx_beat_type                     o_dma_beat,
  output logic                                             o_rx_irq,
  output logic                                             o_eof_busy,
  output logic                                             o_overrun,
  output logic      [15:0]                                 o_overrun_count,
  input  wire logic                                        i_overrun_clear
);
  hrdoc_pkg::hrdoc_state_type state;
  hrdoc_pkg::hrdoc_state_type next_state;
  logic [7:0]   rx_fifo [hrdoc_pkg::FIFO_DEPTH];
  logic         rx_last [hrdoc_pkg::FIFO_DEPTH];
  logic [6:0]   wr_ptr;
  logic [6:0]   rd_ptr;
  logic [7:0]   fill;
  logic         fifo_full;
  logic         drop;
  logic         srch_start;
  logic         srch_busy;
  logic         srch_done;
  logic         srch_match;
  logic         pending;
  logic [15:0]  chain_cnt;
  logic [15:0]  buf_bytes;
  logic         xfer_pop;
  logic         buf_valid;
  logic         buf_ready;
  logic [3:0]   buf_count;
  logic [8:0]   buf_out;
  logic         ovr_event;

  assign fifo_full = (fill == 8'(hrdoc_pkg::FIFO_DEPTH));
  assign ovr_event = i_rx_valid && fifo_full && !drop;
  assign xfer_pop  = (state == hrdoc_pkg::ST_XFER) && (fill != 8'h00) && buf_ready;
  assign srch_start = (state == hrdoc_pkg::ST_SEARCH) && !srch_busy && !srch_done;

  hrdoc_addr_search #(
    .ENTRIES (ENTRIES),
    .IW      (IW)
  ) u_search (
    .i_core_clk (i_core_clk),
    .i_rst_b    (i_rst_b),
    .i_start    (srch_start),
    .i_rx_addr  (i_rx_addr),
    .i_count    (i_address_table_setting),
    .i_table    (i_addr_table),
    .o_busy     (srch_busy),
    .o_done     (srch_done),
    .o_match    (srch_match)
  );

  hrdoc_fifo #(
    .WIDTH (9),
    .DEPTH (hrdoc_pkg::BUF_DEPTH),
    .AW    (3)
  ) u_buf (
    .i_core_clk (i_core_clk),
    .i_rst_b    (i_rst_b),
    .i_flush    (1'b0),
    .i_valid    (xfer_pop),
    .o_ready    (buf_ready),
    .i_data     ({rx_fifo[rd_ptr], rx_last[rd_ptr]}),
    .o_valid    (buf_valid),
    .i_ready    (i_dma_ready),
    .o_data     (buf_out),
    .o_count    (buf_count)
  );

  assign o_dma_valid = buf_valid;
  assign o_dma_beat  = '{data: buf_out[8:1], last: buf_out[0]};

  // Receive FIFO; new data is dropped once full, until frame end
  always_ff @(posedge i_core_clk) begin
    if (i_rx_valid && !fifo_full && !drop) begin
      rx_fifo[wr_ptr] <= i_rx_beat.data;
      rx_last[wr_ptr] <= i_rx_beat.last;
    end else if (ovr_event) begin
      // Close the stored part so the engine does not wait for a lost end byte
      rx_last[wr_ptr - 7'h1] <= 1'b1;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_b) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      fill   <= 8'h00;
    end else begin
      if (i_rx_valid && !fifo_full && !drop) begin
        wr_ptr <= wr_ptr + 7'h1;
      end
      if (xfer_pop) begin
        rd_ptr <= rd_ptr + 7'h1;
      end
      fill <= fill + 8'(i_rx_valid && !fifo_full && !drop) - 8'(xfer_pop);
    end
  end

  // Discard rest of an overrun frame
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_b) begin
      drop <= 1'b0;
    end else if (ovr_event && !i_rx_beat.last) begin
      drop <= 1'b1;
    end else if (i_rx_valid && i_rx_beat.last) begin
      drop <= 1'b0;
    end
  end

  // Sticky overrun flag and count; new overrun wins over clear
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_b) begin
      o_overrun       <= 1'b0;
      o_overrun_count <= hrdoc_pkg::OVR_CNT_RESET;
    end else begin
      if (ovr_event) begin
        o_overrun       <= 1'b1;
        o_overrun_count <= o_overrun_count + 16'h0001;
      end else if (i_overrun_clear) begin
        o_overrun <= 1'b0;
      end
    end
  end

  // Frame start waiting for service
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_b) begin
      pending <= 1'b0;
    end else if (i_rx_valid && state == hrdoc_pkg::ST_IDLE && fill == 8'h00) begin
      pending <= 1'b1;
    end else if ((state == hrdoc_pkg::ST_IDLE || state == hrdoc_pkg::ST_WAIT_RPT) &&
                 !i_report_busy) begin
      pending <= 1'b0;
    end
  end

  always_comb begin
    next_state = state;
    unique case (state)
      hrdoc_pkg::ST_IDLE: begin
        if ((pending || fill != 8'h00) && !i_report_busy) begin
          next_state = (i_address_match != hrdoc_pkg::MATCH_OFF) ?
                       hrdoc_pkg::ST_SEARCH : hrdoc_pkg::ST_XFER;
        end else if (pending || fill != 8'h00) begin
          next_state = hrdoc_pkg::ST_WAIT_RPT;
        end
      end
      hrdoc_pkg::ST_WAIT_RPT: begin
        if (!i_report_busy) begin
          next_state = (i_address_match != hrdoc_pkg::MATCH_OFF) ?
                       hrdoc_pkg::ST_SEARCH : hrdoc_pkg::ST_XFER;
        end
      end
      hrdoc_pkg::ST_SEARCH: begin
        if (srch_done) begin
          next_state = srch_match ? hrdoc_pkg::ST_XFER : hrdoc_pkg::ST_EOF;
        end
      end
      hrdoc_pkg::ST_XFER: begin
        if (xfer_pop && rx_last[rd_ptr]) begin
          next_state = hrdoc_pkg::ST_EOF;
        end else if (xfer_pop && i_chain_en && buf_bytes == 16'(BUF_LEN - 1)) begin
          next_state = hrdoc_pkg::ST_CHAIN;
        end
      end
      hrdoc_pkg::ST_CHAIN: begin
        if (chain_cnt == 16'h0001) begin
          next_state = hrdoc_pkg::ST_XFER;
        end
      end
      hrdoc_pkg::ST_EOF: begin
        if (i_eof_done) begin
          next_state = hrdoc_pkg::ST_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_b) begin
      state <= hrdoc_pkg::ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Chain dead time and buffer byte count
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_b) begin
      chain_cnt <= 16'h0000;
      buf_bytes <= 16'h0000;
    end else begin
      if (next_state == hrdoc_pkg::ST_CHAIN && state != hrdoc_pkg::ST_CHAIN) begin
        chain_cnt <= 16'(CHAIN_CYC);
      end else if (chain_cnt != 16'h0000) begin
        chain_cnt <= chain_cnt - 16'h0001;
      end
      if (state == hrdoc_pkg::ST_XFER && xfer_pop) begin
        buf_bytes <= (buf_bytes == 16'(BUF_LEN - 1)) ? 16'h0000 : buf_bytes + 16'h0001;
      end else if (state == hrdoc_pkg::ST_EOF) begin
        buf_bytes <= 16'h0000;
      end
    end
  end

  // Start pulse and masked reception interrupt
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_b) begin
      o_dma_start <= 1'b0;
      o_rx_irq    <= 1'b0;
      o_eof_busy  <= 1'b0;
    end else begin
      o_dma_start <= (next_state == hrdoc_pkg::ST_XFER) &&
                     (state == hrdoc_pkg::ST_IDLE || state == hrdoc_pkg::ST_WAIT_RPT ||
                      state == hrdoc_pkg::ST_SEARCH);
      o_eof_busy  <= (next_state == hrdoc_pkg::ST_EOF);
      o_rx_irq    <= pending && (state != hrdoc_pkg::ST_EOF);
    end
  end

  // Transmit side is a separate register path
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_b) begin
      o_tx_valid <= 1'b0;
      o_tx_data  <= 8'h00;
    end else begin
      o_tx_valid <= i_tx_valid;
      o_tx_data  <= i_tx_data;
    end
  end

  no_start_report_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    i_report_busy |=> !o_dma_start)
    else $error("dma started during status report");

  no_search_off_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    (i_address_match == hrdoc_pkg::MATCH_OFF) |=> state != hrdoc_pkg::ST_SEARCH ||
    $past(state) == hrdoc_pkg::ST_SEARCH)
    else $error("search entered with match off");

  search_before_xfer_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    $past(state) == hrdoc_pkg::ST_SEARCH && state == hrdoc_pkg::ST_XFER |-> $past(srch_match))
    else $error("transfer began without a match");

  overrun_flag_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    ovr_event |=> o_overrun && o_overrun_count == $past(o_overrun_count) + 16'h0001)
    else $error("overrun not recorded");

  full_no_write_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    fifo_full && !xfer_pop |=> fill == 8'(hrdoc_pkg::FIFO_DEPTH))
    else $error("fifo grew past capacity");

  drop_frame_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    drop && !xfer_pop |=> fill <= $past(fill))
    else $error("discarded frame stored");

  irq_masked_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    state == hrdoc_pkg::ST_EOF |=> !o_rx_irq)
    else $error("irq raised during end processing");

  chain_hold_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    state != hrdoc_pkg::ST_CHAIN ##1 state == hrdoc_pkg::ST_CHAIN |->
    state == hrdoc_pkg::ST_CHAIN [*8])
    else $error("chain dead time too short");

  tx_pass_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    i_tx_valid |=> o_tx_valid && o_tx_data == $past(i_tx_data))
    else $error("transmit path stalled");
endmodule
`default_nettype wire

// ---- hrdoc_pkg.sv ----
`default_nettype none
package hrdoc_pkg;

  localparam int unsigned FIFO_DEPTH       = 128;
  localparam int unsigned FIFO_ADDR_W      = 7;
  localparam int unsigned DATA_W           = 8;
  localparam int unsigned BUF_DEPTH        = 8;
  localparam int unsigned CLK_MHZ          = 125;
  localparam int unsigned CHAIN_NS         = 13000;
  localparam int unsigned CHAIN_CYC        = (CHAIN_NS * CLK_MHZ) / 1000;
  localparam int unsigned TBL_ENTRIES      = 16;
  localparam int unsigned TBL_IDX_W        = 4;
  localparam logic [7:0]  MATCH_OFF        = 8'h00;
  localparam logic [15:0] OVR_CNT_RESET    = 16'h0000;

  typedef struct packed {
    logic [7:0] data;
    logic       last;
  } hrdoc_rx_beat_type;

  typedef struct packed {
    logic [15:0] addr;
    logic        wide;
  } hrdoc_tbl_entry_type;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_SEARCH,
    ST_WAIT_RPT,
    ST_XFER,
    ST_EOF,
    ST_CHAIN
  } hrdoc_state_type;

endpackage
`default_nettype wire

// ---- hrdoc_fifo.sv ----
`timescale 1ns/1ps
`default_nettype none
module hrdoc_fifo #(
  parameter int unsigned WIDTH = 9,
  parameter int unsigned DEPTH = 8,
  parameter int unsigned AW    = 3
) (
  input  wire logic             i_core_clk,
  input  wire logic             i_rst_b,
  input  wire logic             i_flush,
  input  wire logic             i_valid,
  output logic                  o_ready,
  input  wire logic [WIDTH-1:0] i_data,
  output logic                  o_valid,
  input  wire logic             i_ready,
  output logic      [WIDTH-1:0] o_data,
  output logic      [AW:0]      o_count
);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic             push;
  logic             pop;

  assign o_ready = (o_count != (AW+1)'(DEPTH));
  assign o_valid = (o_count != '0);
  assign push    = i_valid && o_ready;
  assign pop     = o_valid && i_ready;
  assign o_data  = mem[rd_ptr];

  always_ff @(posedge i_core_clk) begin
    if (push) begin
      mem[wr_ptr] <= i_data;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_b || i_flush) begin
      wr_ptr  <= '0;
      rd_ptr  <= '0;
      o_count <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + AW'(1);
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + AW'(1);
      end
      o_count <= o_count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  count_bound_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    o_count <= (AW+1)'(DEPTH))
    else $error("fifo count above depth");
endmodule
`default_nettype wire

// ---- hrdoc_addr_search.sv ----
`timescale 1ns/1ps
`default_nettype none
module hrdoc_addr_search #(
  parameter int unsigned ENTRIES = 16,
  parameter int unsigned IW      = 4
) (
  input  wire logic                               i_core_clk,
  input  wire logic                               i_rst_b,
  input  wire logic                               i_start,
  input  wire logic [15:0]                        i_rx_addr,
  input  wire logic [IW:0]                        i_count,
  input  wire hrdoc_pkg::hrdoc_tbl_entry_type [ENTRIES-1:0] i_table,
  output logic                                    o_busy,
  output logic                                    o_done,
  output logic                                    o_match
);
  logic [IW:0] idx;
  logic        hit;

  assign hit = i_table[idx[IW-1:0]].wide ? (i_table[idx[IW-1:0]].addr == i_rx_addr)
             : (i_table[idx[IW-1:0]].addr[7:0] == i_rx_addr[7:0]);

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_b) begin
      o_busy  <= 1'b0;
      o_done  <= 1'b0;
      o_match <= 1'b0;
      idx     <= '0;
    end else begin
      o_done <= 1'b0;
      if (i_start && !o_busy) begin
        o_busy  <= 1'b1;
        o_match <= 1'b0;
        idx     <= '0;
      end else if (o_busy) begin
        if (idx >= i_count || idx == (IW+1)'(ENTRIES)) begin
          o_busy <= 1'b0;
          o_done <= 1'b1;
        end else if (hit) begin
          o_busy  <= 1'b0;
          o_done  <= 1'b1;
          o_match <= 1'b1;
        end else begin
          idx <= idx + (IW+1)'(1);
        end
      end
    end
  end

  match_needs_entry_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    $rose(o_match) |-> $past(o_busy) && $past(idx) < $past(i_count))
    else $error("match reported without a table entry");
endmodule
`default_nettype wire

// ---- hrdoc_mem_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module hrdoc_mem_model (
  input  wire logic                         i_core_clk,
  input  wire logic                         i_rst_b,
  input  wire logic                         i_slow,
  input  wire logic                         i_valid,
  input  wire hrdoc_pkg::hrdoc_rx_beat_type i_beat,
  output logic                              o_ready,
  output logic      [15:0]                  o_beats,
  output logic      [7:0]                   o_frames
);
  logic [7:0] mem [0:255];
  logic       phase;
  // Slow mode stalls every other cycle
  assign o_ready = !(i_slow && phase);
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_b) begin
      phase <= 1'b0;
      o_beats <= 16'h0000;
      o_frames <= 8'h00;
    end else begin
      phase <= !phase;
      if (i_valid && o_ready) begin
        mem[o_beats[7:0]] <= i_beat.data;
        o_beats <= o_beats + 16'h0001;
        o_frames <= o_frames + {7'h00, i_beat.last};
      end
    end
  end
endmodule
`default_nettype wire

// ---- hrdoc_rx_sched_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module hrdoc_rx_sched_tb;
  localparam int CCYC = 20;
  logic clk, rst_b, rx_valid, chain_en, rpt, eof_done, tx_valid, ovr_clr, slow;
  logic dma_start, dma_valid, dma_ready, rx_irq, eof_busy, ovr, o_txv;
  logic [7:0] match, tx_data, o_txd, frames;
  logic [15:0] rx_addr, ovr_cnt, beats;
  logic [4:0] tbl_set;
  hrdoc_pkg::hrdoc_rx_beat_type beat, dma_beat;
  hrdoc_pkg::hrdoc_tbl_entry_type [15:0] tbl;
  int miscompares, num_checks, cyc, lat0, lat;
  int starts, start_cyc, irqs;

  hrdoc_rx_sched #(.CHAIN_CYC(CCYC), .BUF_LEN(4)) i_hrdoc_rx_sched (
    .i_core_clk(clk), .i_rst_b(rst_b), .i_rx_valid(rx_valid), .i_rx_beat(beat),
    .i_rx_addr(rx_addr), .i_address_match(match), .i_address_table_setting(tbl_set),
    .i_addr_table(tbl), .i_chain_en(chain_en), .i_report_busy(rpt),
    .i_eof_done(eof_done), .i_tx_valid(tx_valid), .i_tx_data(tx_data),
    .o_tx_valid(o_txv), .o_tx_data(o_txd), .o_dma_start(dma_start),
    .o_dma_valid(dma_valid), .i_dma_ready(dma_ready), .o_dma_beat(dma_beat),
    .o_rx_irq(rx_irq), .o_eof_busy(eof_busy), .o_overrun(ovr),
    .o_overrun_count(ovr_cnt), .i_overrun_clear(ovr_clr));
  hrdoc_mem_model i_hrdoc_mem_model (
    .i_core_clk(clk), .i_rst_b(rst_b), .i_slow(slow), .i_valid(dma_valid),
    .i_beat(dma_beat), .o_ready(dma_ready), .o_beats(beats), .o_frames(frames));

  initial begin
    clk = 1'b0;
    forever #4 clk = !clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (dma_start === 1'b1) begin
      starts    <= starts + 1;
      start_cyc <= cyc;
    end
    if (rx_irq === 1'b1) irqs <= irqs + 1;
    if (cyc == 60000) begin
      miscompares++;
      complete_run();
    end
  end

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (exp !== got) begin
      miscompares++;
      $display("Error %s expected %0h seen %0h", name, exp, got);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic reset_dut();
    rst_b = 1'b0;
    repeat (6) @(negedge clk);
    rst_b = 1'b1;
  endtask
  task automatic send_byte(input logic [7:0] d, input logic last);
    rx_valid = 1'b1;
    beat = '{data: d, last: last};
    @(negedge clk);
  endtask
  task automatic send_frame(input int n, input logic [7:0] base);
    for (int k = 0; k < n; k++) send_byte(base + 8'(k), k == n - 1);
    rx_valid = 1'b0;
  endtask
  // Cycles from c0 to the first start pulse after s0, 999 if none within the bound
  task automatic wait_start(input int bound, input int s0, input int c0, output int n);
    n = 999;
    for (int k = 0; k < bound && n == 999; k++) begin
      if (starts != s0) n = start_cyc - c0;
      else @(negedge clk);
    end
  endtask
  task automatic finish_frame();
    for (int k = 0; k < 300 && eof_busy !== 1'b1; k++) @(negedge clk);
    chk("eof_busy", 1, eof_busy);
    eof_done = 1'b1;
    @(negedge clk);
    eof_done = 1'b0;
    @(negedge clk);
  endtask

  task automatic t_plain();
    logic [15:0] b0;
    int s0, c0, i0;
    b0 = beats;
    s0 = starts;
    c0 = cyc;
    i0 = irqs;
    slow = 1'b1;
    send_frame(4, 8'h10);
    wait_start(200, s0, c0, lat0);
    chk("plain_start", 2, lat0);
    chk("rx_irq", i0 + 1, irqs);
    repeat (30) @(negedge clk);
    chk("beats", b0 + 4, beats);
    chk("byte3", 8'h13, i_hrdoc_mem_model.mem[b0[7:0] + 3]);
    finish_frame();
    slow = 1'b0;
  endtask
  task automatic t_search();
    int s0, c0;
    s0 = starts;
    c0 = cyc;
    match = 8'h01;
    tbl_set = 5'h04;
    tbl[3] = '{addr: 16'h00A5, wide: 1'b0};
    rx_addr = 16'h00A5;
    send_frame(4, 8'h20);
    wait_start(300, s0, c0, lat);
    chk("search_start", 1, lat < 300);
    chk("search_lat", 1, lat >= lat0 + 3);
    finish_frame();
    match = 8'h00;
  endtask
  task automatic t_report();
    int s0, c0;
    s0 = starts;
    c0 = cyc;
    rpt = 1'b1;
    send_frame(4, 8'h30);
    wait_start(40, s0, c0, lat);
    chk("no_start_busy", 999, lat);
    rpt = 1'b0;
    c0 = cyc;
    wait_start(200, s0, c0, lat);
    chk("start_after", 1, lat < 200);
    finish_frame();
  endtask
  task automatic t_eof();
    int s0, i0;
    send_frame(3, 8'h40);
    for (int k = 0; k < 300 && eof_busy !== 1'b1; k++) @(negedge clk);
    i0 = irqs;
    send_frame(2, 8'h50);
    chk("irq_masked", i0, irqs);
    chk("eof_held", 1, eof_busy);
    s0 = starts;
    finish_frame();
    wait_start(200, s0, cyc, lat);
    chk("next_start", 1, lat < 200);
    finish_frame();
  endtask
  task automatic t_chain();
    int s0;
    s0 = starts;
    chain_en = 1'b1;
    send_frame(6, 8'h60);
    wait_start(200, s0, cyc, lat);
    for (lat = 0; lat < 500 && eof_busy !== 1'b1; lat++) @(negedge clk);
    chk("chain_dead", 1, lat >= CCYC);
    finish_frame();
    chain_en = 1'b0;
  endtask
  task automatic t_ovr();
    logic [15:0] b0;
    b0 = beats;
    rpt = 1'b1;
    for (int k = 0; k < 128; k++) send_byte(8'(k), 1'b0);
    rx_valid = 1'b0;
    repeat (2) @(negedge clk);
    chk("no_ovr_128", 0, ovr);
    tx_valid = 1'b1;
    tx_data = 8'hC3;
    send_byte(8'hFF, 1'b0);
    tx_valid = 1'b0;
    chk("tx_data", 8'hC3, o_txd);
    chk("tx_valid", 1, o_txv);
    send_byte(8'hEE, 1'b1);
    rx_valid = 1'b0;
    chk("ovr_set", 1, ovr);
    chk("ovr_cnt", 1, ovr_cnt);
    ovr_clr = 1'b1;
    @(negedge clk);
    ovr_clr = 1'b0;
    @(negedge clk);
    chk("ovr_clr", 0, ovr);
    chk("cnt_kept", 1, ovr_cnt);
    rpt = 1'b0;
    repeat (400) @(negedge clk);
    chk("frame_dropped", 128, beats - b0);
    finish_frame();
    reset_dut();
    chk("ovr_rst", 0, ovr);
    chk("cnt_rst", 0, ovr_cnt);
  endtask

  initial begin
    {rx_valid, chain_en, rpt, eof_done, tx_valid, ovr_clr, slow} = 7'h00;
    {match, tx_data, rx_addr, tbl_set} = 37'h0;
    beat = '0;
    tbl = '0;
    for (int k = 0; k < 16; k++) tbl[k].addr = 16'h0100 + 16'(k);
    miscompares = 0;
    num_checks = 0;
    cyc = 0;
    starts = 0;
    start_cyc = 0;
    irqs = 0;
    lat0 = 0;
    reset_dut();
    t_plain();
    t_search();
    t_report();
    t_eof();
    t_chain();
    t_ovr();
    complete_run();
  end
endmodule
`default_nettype wire
